// file: design/cib_bridge.sv
// CPU internal bus access: region decode, bus cycles, RMW, CPU states
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - One state per rising edge of active clock
// - Bus cycles last two or three states
// - ROM/RAM: two states, 16-bit, byte or word
// - Peripherals: 8-bit path, byte, two/three states
// - First timer window takes three states
// - Serial and second timer three, other IO two
// - Empty area: writes dropped, reads undefined
// - Word write to IO keeps upper byte
// - Word read from IO: lower half undefined
// - Bit instructions: read, modify, write same byte
// - Four CPU states: reset, execute, halt, exception
// - Execute runs system clock or subclock per mode
// - Halt modes: sleeps, standby, watch, subsleep
// - Exception state brief, after reset or interrupt
// - Interrupt pushes PC and flags via stack pointer
// - No-operation only advances PC by two
module cib_bridge (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Subclock pin, sampled as an ordinary input
	input  wire logic             sub_clk_pin,
	// CPU core request and answer
	input  wire logic             cpu_req_valid,
	input  wire cib_pkg::cib_req_t cpu_req,
	output logic                  cpu_ready,
	output logic                  cpu_ack,
	output logic [15:0]           cpu_rdata,
	// CPU control
	input  wire logic             irq,
	input  wire logic             sleep_req,
	input  wire cib_pkg::cib_halt_t sleep_sel,
	input  wire logic             wake,
	input  wire logic             mode_load,
	input  wire cib_pkg::cib_run_t mode_sel,
	input  wire logic             nop_exec,
	input  wire logic             pc_load,
	input  wire logic [15:0]      pc_val,
	input  wire logic [15:0]      sp_in,
	input  wire logic [7:0]       condition_code_reg,
	// CPU status
	output cib_pkg::cib_cpu_t     cpu_state,
	output cib_pkg::cib_run_t     run_mode,
	output cib_pkg::cib_halt_t    halt_mode,
	output logic [15:0]           pc,
	output logic [15:0]           sp_out,
	output logic                  exc_done,
	// On-chip memory path, 16 bits
	output cib_pkg::cib_mem_t     mem,
	input  wire logic [15:0]      mem_rdata,
	// Peripheral path, 8 bits
	output cib_pkg::cib_io_t      io,
	input  wire logic [7:0]       io_rdata
);
	import cib_pkg::*;

	cib_seq_t    seq;
	cib_req_t    cur;
	cib_req_t    bus_op;
	cib_region_t bus_rg;
	logic        cyc_active;
	logic [1:0]  st_cnt;
	logic        sub_s1;
	logic        sub_s2;
	logic        sub_s3;
	logic        tick;
	logic        done;
	logic        launch;
	cib_req_t    next_op;
	logic [15:0] rd_now;
	logic        exc_reset;
	logic        take;
	logic        exc_end;
	cib_region_t next_rg;

	////////////////////////////////////////////////////////////////////////
	// Subclock edge; second and third stages feed the edge detector
	always_ff @(posedge clk) begin
		if (rst) begin
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else begin
			sub_s1 <= sub_clk_pin;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end
	// A state is one clk edge, or one subclock rise in subactive mode
	assign tick = (run_mode == RM_SUB) ? (sub_s2 & ~sub_s3) : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Bus cycle engine
	assign done = cyc_active && tick &&
		(st_cnt == bus_rg.nstates - 2'h1);
	assign next_rg = decode(next_op.addr);
	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_active <= 1'b0;
			st_cnt     <= 2'h0;
			bus_op     <= '0;
			bus_rg     <= '{RG_EMPTY, STATES_FAST};
			mem        <= '0;
			io         <= '0;
		end else if (launch) begin
			cyc_active <= 1'b1;
			st_cnt     <= 2'h0;
			bus_op     <= next_op;
			bus_rg     <= next_rg;
			// Empty area gets no strobe, so writes vanish
			mem.req    <= next_rg.kind == RG_MEM;
			mem.we     <= next_op.we;
			mem.addr   <= {next_op.addr[15:1], 1'b0};
			mem.be     <= next_op.word ? 2'h3 :
				(next_op.addr[0] ? 2'h1 : 2'h2);
			mem.wdata  <= next_op.word ? next_op.wdata :
				{next_op.wdata[7:0], next_op.wdata[7:0]};
			io.req     <= next_rg.kind == RG_IO;
			io.we      <= next_op.we;
			io.addr    <= next_op.addr;
			// Lower byte of a word write is lost
			io.wdata   <= next_op.word ? next_op.wdata[15:8] :
				next_op.wdata[7:0];
		end else if (done) begin
			cyc_active <= 1'b0;
			mem.req    <= 1'b0;
			io.req     <= 1'b0;
		end else if (cyc_active && tick) begin
			st_cnt     <= st_cnt + 2'h1;
		end
	end
	// Read data as the CPU sees it
	always_comb begin
		rd_now = {UNDEF_BYTE, UNDEF_BYTE};
		case (bus_rg.kind)
			RG_MEM: rd_now = bus_op.word ? mem_rdata : {8'h00,
				bus_op.addr[0] ? mem_rdata[7:0] : mem_rdata[15:8]};
			RG_IO: rd_now = bus_op.word ? {io_rdata, UNDEF_BYTE} :
				{8'h00, io_rdata};
			default: rd_now = {UNDEF_BYTE, UNDEF_BYTE};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: access, read-modify-write, exception pushes
	assign cpu_ready = (seq == SQ_IDLE) && (cpu_state == CS_EXEC) &&
		!irq && !sleep_req;
	assign take = cpu_ready && cpu_req_valid;
	assign exc_end = done && (seq == SQ_PUSH_CCR);
	always_comb begin
		launch  = 1'b0;
		next_op = '0;
		case (seq)
			SQ_IDLE: begin
				if (take) begin
					launch  = 1'b1;
					next_op = cpu_req;
					// Bit instructions start with a byte read
					next_op.we   = cpu_req.we & ~cpu_req.rmw;
					next_op.word = cpu_req.word & ~cpu_req.rmw;
				end else if (cpu_state == CS_EXCEPT && !exc_reset) begin
					launch        = 1'b1;
					next_op.addr  = sp_in - STACK_STEP;
					next_op.we    = 1'b1;
					next_op.word  = 1'b1;
					next_op.wdata = pc;
				end
			end
			SQ_ACCESS: begin
				if (done && cur.rmw) begin
					launch        = 1'b1;
					next_op       = cur;
					next_op.we    = 1'b1;
					next_op.word  = 1'b0;
					next_op.wdata = {8'h00,
						bit_op(rd_now[7:0], cur.op, cur.bitn, cur.cbit)};
				end
			end
			SQ_PUSH_PC: begin
				if (done) begin
					launch        = 1'b1;
					next_op.addr  = sp_in - STACK_STEP - STACK_STEP;
					next_op.we    = 1'b1;
					next_op.word  = 1'b1;
					next_op.wdata = {condition_code_reg, condition_code_reg};
				end
			end
			default: launch = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			seq <= SQ_IDLE;
			cur <= '0;
		end else begin
			case (seq)
				SQ_IDLE: begin
					if (take) begin
						seq <= SQ_ACCESS;
						cur <= cpu_req;
					end else if (launch)
						seq <= SQ_PUSH_PC;
				end
				SQ_ACCESS:
					if (done)
						seq <= cur.rmw ? SQ_MODWR : SQ_IDLE;
				SQ_MODWR:
					if (done)
						seq <= SQ_IDLE;
				SQ_PUSH_PC:
					if (done)
						seq <= SQ_PUSH_CCR;
				SQ_PUSH_CCR:
					if (done)
						seq <= SQ_IDLE;
				default: seq <= SQ_IDLE;
			endcase
		end
	end
	// Answer to the core; bit instructions return the byte read
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_ack   <= 1'b0;
			cpu_rdata <= 16'h0000;
		end else begin
			cpu_ack <= done && ((seq == SQ_ACCESS && !cur.rmw) ||
				seq == SQ_MODWR);
			if (done && seq == SQ_ACCESS)
				cpu_rdata <= rd_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CPU state machine
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_state <= CS_RESET;
			exc_reset <= 1'b1;
			halt_mode <= HM_SLEEP_HI;
			exc_done  <= 1'b0;
			sp_out    <= 16'h0000;
		end else begin
			exc_done <= 1'b0;
			case (cpu_state)
				CS_RESET: cpu_state <= CS_EXCEPT;
				CS_EXEC: begin
					if (irq && seq == SQ_IDLE) begin
						cpu_state <= CS_EXCEPT;
						exc_reset <= 1'b0;
					end else if (sleep_req && seq == SQ_IDLE) begin
						cpu_state <= CS_HALT;
						halt_mode <= sleep_sel;
					end
				end
				CS_HALT: begin
					// Interrupt leaves halt through exception handling
					if (irq) begin
						cpu_state <= CS_EXCEPT;
						exc_reset <= 1'b0;
					end else if (wake)
						cpu_state <= CS_EXEC;
				end
				CS_EXCEPT: begin
					if (exc_reset || exc_end) begin
						cpu_state <= CS_EXEC;
						exc_done  <= 1'b1;
						exc_reset <= 1'b0;
						if (exc_end)
							sp_out <= sp_in - STACK_STEP - STACK_STEP;
					end
				end
				default: cpu_state <= CS_RESET;
			endcase
		end
	end

	// Run mode and program counter
	always_ff @(posedge clk) begin
		if (rst) begin
			run_mode <= RM_HIGH;
			pc       <= PC_RESET;
		end else begin
			if (mode_load && cpu_state == CS_EXEC)
				run_mode <= mode_sel;
			if (pc_load)
				pc <= pc_val;
			else if (nop_exec && cpu_state == CS_EXEC)
				pc <= pc + PC_STEP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_mem_two_states: assert property (@(posedge clk) disable iff (rst)
		done && bus_rg.kind == RG_MEM |-> st_cnt == 2'h1)
		else $error("memory cycle not two states");
	chk_timer_three: assert property (@(posedge clk) disable iff (rst)
		done && in_rng(bus_op.addr, IO1_LO, IO1_HI) |-> st_cnt == 2'h2)
		else $error("first timer cycle not three states");
	chk_upper_io_len: assert property (@(posedge clk) disable iff (rst)
		done && bus_rg.kind == RG_IO && bus_op.addr >= IO2_LO |->
		st_cnt == ((in_rng(bus_op.addr, SCI_LO, SCI_HI) ||
		in_rng(bus_op.addr, TMV_LO, TMV_HI)) ? 2'h2 : 2'h1))
		else $error("upper io cycle length wrong");
	chk_empty_no_strobe: assert property (@(posedge clk) disable iff (rst)
		cyc_active && bus_rg.kind == RG_EMPTY |-> !mem.req && !io.req)
		else $error("strobe on empty area");
	chk_io_word_write: assert property (@(posedge clk) disable iff (rst)
		io.req && io.we && bus_op.word |-> io.wdata == bus_op.wdata[15:8])
		else $error("io word write lost upper byte");
	chk_io_word_read: assert property (@(posedge clk) disable iff (rst)
		done && seq == SQ_ACCESS && bus_rg.kind == RG_IO && bus_op.word
		|=> cpu_rdata == {$past(io_rdata), UNDEF_BYTE})
		else $error("io word read halves wrong");
	chk_rmw_write_back: assert property (@(posedge clk) disable iff (rst)
		done && seq == SQ_ACCESS && cur.rmw |=> seq == SQ_MODWR &&
		bus_op.we && !bus_op.word && bus_op.addr == cur.addr)
		else $error("bit instruction write-back wrong");
	chk_push_pc: assert property (@(posedge clk) disable iff (rst)
		seq == SQ_PUSH_PC && mem.req |->
		mem.addr == sp_in - STACK_STEP && mem.wdata == pc && mem.we)
		else $error("pc push wrong");
	chk_nop_step: assert property (@(posedge clk) disable iff (rst)
		nop_exec && !pc_load && cpu_state == CS_EXEC |=>
		pc == $past(pc) + PC_STEP)
		else $error("no-operation did not add two");
	chk_reset_brief: assert property (@(posedge clk) disable iff (rst)
		!rst && cpu_state == CS_RESET |=> cpu_state == CS_EXCEPT ##1
		cpu_state == CS_EXEC)
		else $error("reset exception not brief");
endmodule : cib_bridge

// file: design/cib_pkg.sv
// Constants, types and decode helpers for the CPU internal bus access block
package cib_pkg;

	// Address map
	localparam logic [15:0] VEC_END   = 16'h002F;
	localparam logic [15:0] ROM_END   = 16'hEDFF;
	localparam logic [15:0] IO1_LO    = 16'hF770;
	localparam logic [15:0] IO1_HI    = 16'hF77F;
	localparam logic [15:0] RAM_LO    = 16'hF780;
	localparam logic [15:0] RAM_HI    = 16'hFF7F;
	localparam logic [15:0] IO2_LO    = 16'hFFA0;
	localparam logic [15:0] SCI_LO    = 16'hFFA8;
	localparam logic [15:0] SCI_HI    = 16'hFFAD;
	localparam logic [15:0] TMV_LO    = 16'hFFB8;
	localparam logic [15:0] TMV_HI    = 16'hFFBD;

	// Cycle lengths in states, undefined read pattern, stack and PC steps
	localparam logic [1:0]  STATES_FAST = 2'h2;
	localparam logic [1:0]  STATES_SLOW = 2'h3;
	localparam logic [7:0]  UNDEF_BYTE  = 8'hFF;
	localparam logic [15:0] PC_STEP     = 16'h0002;
	localparam logic [15:0] STACK_STEP  = 16'h0002;
	localparam logic [15:0] PC_RESET    = 16'h0000;

	typedef enum logic [1:0] {RG_MEM, RG_IO, RG_EMPTY} cib_kind_t;
	typedef enum logic [2:0] {BOP_SET, BOP_CLR, BOP_NOT, BOP_ST,
		BOP_IST} cib_bop_t;
	typedef enum logic [1:0] {CS_RESET = 2'b00, CS_EXEC = 2'b01,
		CS_EXCEPT = 2'b11, CS_HALT = 2'b10} cib_cpu_t;
	typedef enum logic [2:0] {SQ_IDLE = 3'b000, SQ_ACCESS = 3'b001,
		SQ_MODWR = 3'b011, SQ_PUSH_PC = 3'b010,
		SQ_PUSH_CCR = 3'b110} cib_seq_t;
	typedef enum logic [1:0] {RM_HIGH, RM_MED, RM_SUB} cib_run_t;
	typedef enum logic [2:0] {HM_SLEEP_HI, HM_SLEEP_MED, HM_STANDBY,
		HM_WATCH, HM_SUBSLEEP} cib_halt_t;

	typedef struct packed {
		cib_kind_t  kind;
		logic [1:0] nstates;
	} cib_region_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        we;
		logic        word;
		logic [15:0] wdata;
		logic        rmw;
		cib_bop_t    op;
		logic [2:0]  bitn;
		logic        cbit;
	} cib_req_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [1:0]  be;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cib_mem_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cib_io_t;

	function automatic logic in_rng(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	function automatic cib_region_t decode(input logic [15:0] a);
		decode = '{RG_EMPTY, STATES_FAST};
		if (a <= ROM_END)
			decode = '{RG_MEM, STATES_FAST};
		else if (in_rng(a, IO1_LO, IO1_HI))
			decode = '{RG_IO, STATES_SLOW};
		else if (in_rng(a, RAM_LO, RAM_HI))
			decode = '{RG_MEM, STATES_FAST};
		else if (in_rng(a, SCI_LO, SCI_HI) || in_rng(a, TMV_LO, TMV_HI))
			decode = '{RG_IO, STATES_SLOW};
		else if (a >= IO2_LO)
			decode = '{RG_IO, STATES_FAST};
	endfunction : decode

	function automatic logic [7:0] bit_op(input logic [7:0] d,
		input cib_bop_t op, input logic [2:0] n, input logic c);
		bit_op = d;
		case (op)
			BOP_SET: bit_op[n] = 1'b1;
			BOP_CLR: bit_op[n] = 1'b0;
			BOP_NOT: bit_op[n] = ~d[n];
			BOP_ST:  bit_op[n] = c;
			BOP_IST: bit_op[n] = ~c;
			default: bit_op = d;
		endcase
	endfunction : bit_op

endpackage : cib_pkg

// file: sim/cib_far_model.sv
// Memory and peripheral model on the far side of the bridge
`timescale 1ns/1ps
module cib_far_model (
	// Clock
	input  wire logic              clk,
	// 16-bit memory path
	input  wire cib_pkg::cib_mem_t mem,
	output logic [15:0]            mem_rdata,
	// 8-bit peripheral path
	input  wire cib_pkg::cib_io_t  io,
	output logic [7:0]             io_rdata
);
	import cib_pkg::*;
	logic [7:0]  m [0:65535];
	logic [15:0] lm;
	logic [7:0]  li;
	initial begin
		for (int i = 0; i < 65536; i++) m[i] = i[7:0] ^ i[15:8];
		lm = 16'h0000;
		li = 8'h00;
	end
	// Released paths show the inverse of the last value, not a stale copy
	assign mem_rdata = mem.req ? {m[mem.addr], m[mem.addr | 16'h0001]} : ~lm;
	assign io_rdata  = io.req ? m[io.addr] : ~li;
	always @(posedge clk) begin
		if (mem.req)
			lm <= mem_rdata;
		if (io.req)
			li <= io_rdata;
		if (mem.req && mem.we && mem.be[1])
			m[mem.addr] <= mem.wdata[15:8];
		if (mem.req && mem.we && mem.be[0])
			m[mem.addr | 16'h0001] <= mem.wdata[7:0];
		if (io.req && io.we)
			m[io.addr] <= io.wdata;
	end
endmodule : cib_far_model

// file: sim/cpu_internal_bus_access_tb.sv
// Self-checking bench for the CPU internal bus access bridge
`timescale 1ns/1ps
module cpu_internal_bus_access_tb;
	import cib_pkg::*;
	logic        clk, rst, sub_clk_pin, cpu_req_valid, irq, sleep_req;
	logic        wake, mode_load, nop_exec, pc_load, cpu_ready, cpu_ack;
	logic        exc_done, in_sub;
	cib_req_t    cpu_req;
	cib_halt_t   sleep_sel;
	cib_halt_t   halt_mode;
	cib_run_t    mode_sel;
	cib_run_t    run_mode;
	cib_cpu_t    cpu_state;
	cib_mem_t    mem;
	cib_io_t     io;
	logic [15:0] pc_val, sp_in, cpu_rdata, pc, sp_out, mem_rdata, rd;
	logic [7:0]  condition_code_reg, io_rdata;
	logic [31:0] v;
	logic [7:0]  sh [0:65535];
	int          bad_count, tests_run, seed, nreq;
	logic [15:0] tbl [20] = '{16'h0000, 16'h0030, 16'hEDFF, 16'hEE00,
		16'hF76F, 16'hF770, 16'hF77F, 16'hF780, 16'hFF7F, 16'hFF80,
		16'hFF9F, 16'hFFA0, 16'hFFA7, 16'hFFA8, 16'hFFAD, 16'hFFAE,
		16'hFFB8, 16'hFFBD, 16'hFFBE, 16'hFFFF};
	logic [15:0] ba [4] = '{16'hF800, 16'h0101, 16'hF771, 16'hFFC0};

	cib_bridge uut (.clk(clk), .rst(rst), .sub_clk_pin(sub_clk_pin),
		.cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req),
		.cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.irq(irq), .sleep_req(sleep_req), .sleep_sel(sleep_sel),
		.wake(wake), .mode_load(mode_load), .mode_sel(mode_sel),
		.nop_exec(nop_exec), .pc_load(pc_load), .pc_val(pc_val),
		.sp_in(sp_in), .condition_code_reg(condition_code_reg),
		.cpu_state(cpu_state), .run_mode(run_mode),
		.halt_mode(halt_mode), .pc(pc), .sp_out(sp_out),
		.exc_done(exc_done), .mem(mem), .mem_rdata(mem_rdata),
		.io(io), .io_rdata(io_rdata));
	cib_far_model far (.clk(clk), .mem(mem), .mem_rdata(mem_rdata),
		.io(io), .io_rdata(io_rdata));

	////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic chk(input logic ok, input string s);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("FAIL %0t %s", $time, s);
		end
	endtask : chk

	function automatic logic io_a(input logic [15:0] a);
		return (a >= 16'hF770 && a <= 16'hF77F) || a >= 16'hFFA0;
	endfunction : io_a

	function automatic int exp_st(input logic [15:0] a);
		if (a <= 16'hEDFF || (a >= 16'hF780 && a <= 16'hFF7F))
			return 2;
		if ((a >= 16'hF770 && a <= 16'hF77F) || (a >= 16'hFFA8 &&
			a <= 16'hFFAD) || (a >= 16'hFFB8 && a <= 16'hFFBD))
			return 3;
		return (a >= 16'hFFA0) ? 2 : 0;
	endfunction : exp_st

	task automatic wexc();
		for (int t = 0; t < 60 && exc_done !== 1'b1; t++)
			@(negedge clk);
	endtask : wexc

	// Holds the request until the take edge, then counts strobe cycles
	task automatic acc(input logic [15:0] a, input logic we, wd,
		input logic [15:0] d, input logic rm, input cib_bop_t o,
		input logic [2:0] n, input logic c);
		int t;
		while (cpu_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		cpu_req_valid <= 1'b1;
		cpu_req <= '{a, we, wd, d, rm, o, n, c};
		@(posedge clk);
		cpu_req_valid <= 1'b0;
		nreq = 0;
		t = 0;
		do begin
			@(negedge clk);
			t++;
			if (mem.req === 1'b1 || io.req === 1'b1)
				nreq++;
		end while (cpu_ack !== 1'b1 && t < 200);
		rd = cpu_rdata;
		chk(t < 200, "no ack");
	endtask : acc

	task automatic op(input logic [15:0] a, input logic we, wd,
		input logic [15:0] d);
		int s;
		logic [15:0] e;
		s = exp_st(a);
		e = (s == 0) ? 16'hFFFF : !wd ? {8'h00, sh[a]} :
			io_a(a) ? {sh[a], 8'hFF} : {sh[a], sh[a + 16'h0001]};
		acc(a, we, wd, d, 1'b0, BOP_SET, 3'h0, 1'b0);
		if (!in_sub)
			chk(nreq === s, "state count");
		else
			chk(nreq > 8 * s - 8 && nreq <= 8 * s, "sub states");
		if (!we)
			chk(rd === e, "read data");
		else if (s != 0 && (!wd || io_a(a)))
			sh[a] = wd ? d[15:8] : d[7:0];
		else if (s != 0) begin
			sh[a] = d[15:8];
			sh[a + 16'h0001] = d[7:0];
		end
	endtask : op

	task automatic bop(input logic [15:0] a, input cib_bop_t o,
		input logic [2:0] n, input logic c);
		logic [7:0] b;
		b = sh[a];
		acc(a, 1'b0, 1'b0, 16'h0000, 1'b1, o, n, c);
		chk(nreq === 2 * exp_st(a) && rd === {8'h00, b}, "rmw");
		case (o)
			BOP_SET: b[n] = 1'b1;
			BOP_CLR: b[n] = 1'b0;
			BOP_NOT: b[n] = ~b[n];
			BOP_ST:  b[n] = c;
			default: b[n] = ~c;
		endcase
		sh[a] = b;
		op(a, 1'b0, 1'b0, 16'h0000);
	endtask : bop

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Slow toggle stands in for the subclock
	always begin
		repeat (4) @(posedge clk);
		sub_clk_pin <= ~sub_clk_pin;
	end
	initial begin
		#300000;
		bad_count++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		sub_clk_pin = 1'b0;
		cpu_req_valid = 1'b0;
		cpu_req = '0;
		irq = 1'b0;
		sleep_req = 1'b0;
		sleep_sel = HM_SLEEP_HI;
		wake = 1'b0;
		mode_load = 1'b0;
		mode_sel = RM_HIGH;
		nop_exec = 1'b0;
		pc_load = 1'b0;
		pc_val = 16'h0000;
		sp_in = 16'hF900;
		condition_code_reg = 8'h00;
		in_sub = 1'b0;
		bad_count = 0;
		tests_run = 0;
		seed = 32'h53A6;
		for (int i = 0; i < 65536; i++) sh[i] = i[7:0] ^ i[15:8];
		repeat (8) @(posedge clk);
		chk(cpu_state === CS_RESET && pc === 16'h0000, "reset");
		rst <= 1'b0;
		wexc();
		chk(exc_done === 1'b1 && cpu_state === CS_EXEC, "boot");
		$display("test reset done");
		foreach (tbl[i]) begin
			v = $random(seed);
			op(tbl[i], 1'b1, 1'b0, v[15:0]);
			op(tbl[i], 1'b0, 1'b0, 16'h0000);
			op(tbl[i] & 16'hFFFE, 1'b1, 1'b1, v[31:16]);
			op(tbl[i] & 16'hFFFE, 1'b0, 1'b1, 16'h0000);
		end
		repeat (300) begin
			v = $random(seed);
			op({v[18] ? 4'hF : v[31:28], v[11:1], v[0] & ~v[17]},
				v[16], v[17], v[31:16]);
		end
		$display("test map done");
		for (int k = 0; k < 5; k++)
			foreach (ba[j]) begin
				v = $random(seed);
				bop(ba[j], cib_bop_t'(k), v[2:0], v[3]);
			end
		$display("test bit ops done");
		@(posedge clk);
		pc_load <= 1'b1;
		pc_val <= 16'h1FFE;
		@(posedge clk);
		pc_load <= 1'b0;
		nop_exec <= 1'b1;
		repeat (2) @(posedge clk);
		nop_exec <= 1'b0;
		@(negedge clk);
		chk(pc === 16'h2002, "nop");
		for (int k = 2; k >= 0; k--) begin
			@(posedge clk);
			mode_load <= 1'b1;
			mode_sel <= cib_run_t'(k);
			@(posedge clk);
			mode_load <= 1'b0;
			@(negedge clk);
			chk(run_mode === cib_run_t'(k), "run mode");
			in_sub = (k == 2);
			op(16'hF810, 1'b1, 1'b1, 16'hA55A);
			op(16'hF810, 1'b0, 1'b1, 16'h0000);
		end
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			sleep_req <= 1'b1;
			sleep_sel <= cib_halt_t'(k);
			@(posedge clk);
			sleep_req <= 1'b0;
			repeat (2) @(negedge clk);
			chk(cpu_state === CS_HALT && halt_mode === cib_halt_t'(k),
				"halt");
			@(posedge clk);
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			repeat (2) @(negedge clk);
			chk(cpu_state === CS_EXEC, "wake");
		end
		$display("test modes done");
		v = $random(seed);
		@(posedge clk);
		condition_code_reg <= v[7:0];
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		wexc();
		chk(exc_done === 1'b1 && sp_out === 16'hF8FC, "irq");
		sh[16'hF8FE] = 8'h20;
		sh[16'hF8FF] = 8'h02;
		sh[16'hF8FC] = v[7:0];
		sh[16'hF8FD] = v[7:0];
		op(16'hF8FE, 1'b0, 1'b1, 16'h0000);
		op(16'hF8FC, 1'b0, 1'b1, 16'h0000);
		$display("test interrupt done");
		final_report();
	end
endmodule : cpu_internal_bus_access_tb
